// [hw/pwr_seq_pkg.sv]
// shared constants for the audio converter power-mode sequencer pair
`default_nettype none
package pwr_seq_pkg;
    // clock and waits
    localparam int CLK_HZ = 10_000_000;
    localparam int INIT_WAIT_US = 1000;
    localparam int WAKE_WAIT_US = 1000;
    localparam int SLEEP_WAIT_US = 6000;
    localparam int INIT_WAIT_CYC = (INIT_WAIT_US * (CLK_HZ / 1_000_000));
    localparam int WAKE_WAIT_CYC = (WAKE_WAIT_US * (CLK_HZ / 1_000_000));
    localparam int SLEEP_WAIT_CYC = (SLEEP_WAIT_US * (CLK_HZ / 1_000_000));
    // the device finishes its own sequences sooner than the host's margin
    localparam int DEV_INIT_CYC = INIT_WAIT_CYC / 2;
    localparam int DEV_WAKE_CYC = WAKE_WAIT_CYC / 2;
    localparam int DEV_SLEEP_CYC = SLEEP_WAIT_CYC / 2;
    // register addresses
    localparam logic [7:0] SLEEP_CONTROL_ADDR = 8'h02;
    localparam logic [7:0] INPUT_CHANNEL_ENABLE_ADDR = 8'h73;
    localparam logic [7:0] OUTPUT_SLOT_ENABLE_ADDR = 8'h74;
    localparam logic [7:0] BLOCK_POWER_UP_ADDR = 8'h75;
    localparam logic [7:0] DEVICE_STATUS_ADDR = 8'h77;
    // field positions and values
    localparam int SLEEP_BIT = 0;
    localparam int STATUS_SLEEP_BIT = 7;
    localparam logic [7:0] WAKE_VALUE = 8'h81;
    localparam logic [7:0] SLEEP_VALUE = 8'h80;
    localparam logic [7:0] CHANNEL_EN_VALUE = 8'hf0;
    localparam logic [7:0] SLOT_EN_VALUE = 8'hf0;
    localparam logic [7:0] POWER_UP_VALUE = 8'he0;
    // reset values
    localparam logic [7:0] SLEEP_CONTROL_RST = 8'h00;
    localparam logic [7:0] ENABLE_RST = 8'h00;
    // serial frame
    localparam int SLOT_BITS = 8;
    localparam int SLOTS = 4;
endpackage
`default_nettype wire

// [hw/pwr_seq_if.sv]
// connection between host sequencer and device power-mode logic
`timescale 1ns/10ps
`default_nettype none
interface pwr_seq_if;
    logic shutdown_n_pin; // host drives, active low
    logic wr_valid; // one-cycle register write
    logic rd_valid; // one-cycle register read
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata; // valid the cycle after rd_valid
    logic rdata_valid;
    logic frame_sync; // host clock-enable pulses
    logic bit_clk;
    logic serial_data; // device to host
    modport dev (input shutdown_n_pin, input wr_valid, input rd_valid, input addr, input wdata,
        output rdata, output rdata_valid, input frame_sync, input bit_clk, output serial_data);
    modport host (output shutdown_n_pin, output wr_valid, output rd_valid, output addr,
        output wdata, input rdata, input rdata_valid, output frame_sync, output bit_clk,
        input serial_data);
endinterface
`default_nettype wire

// [hw/pwr_seq_host.sv]
// host sequencer that walks the converter through its power modes
`timescale 1ns/10ps
`default_nettype none
module pwr_seq_host #(
    parameter int INIT_CYC = pwr_seq_pkg::INIT_WAIT_CYC,
    parameter int WAKE_CYC = pwr_seq_pkg::WAKE_WAIT_CYC,
    parameter int SLEEP_CYC = pwr_seq_pkg::SLEEP_WAIT_CYC,
    parameter int BCLK_DIV = 4
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic supplies_ok, // from outside, synchronised
    input wire logic record_req, // level: want active
    input wire logic shutdown_req, // level: force hardware shutdown
    output logic active_o,
    output logic asleep_o,
    output logic [7:0] sample_o,
    output logic sample_valid_o,
    pwr_seq_if.host bus
);
    initial begin
        if (INIT_CYC < 1 || WAKE_CYC < 1 || SLEEP_CYC < 1 || BCLK_DIV < 2) begin
            $error("pwr_seq_host: bad parameter");
        end
    end

    typedef enum logic [9:0] {
        S_OFF = 10'h001, S_INIT = 10'h002, S_SLEEP = 10'h004, S_WAKE = 10'h008,
        S_CFG = 10'h010, S_RUN = 10'h020, S_ENTER = 10'h040, S_POLL = 10'h080,
        S_PWAIT = 10'h100, S_REWAKE = 10'h200
    } hstate_t;

    // ---------------------------------------------------------------
    // input synchronisers
    // ---------------------------------------------------------------
    logic sup_m_r, sup_r;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sup_m_r <= 1'b0;
            sup_r <= 1'b0;
        end else begin
            sup_m_r <= supplies_ok;
            sup_r <= sup_m_r;
        end
    end

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    hstate_t st_r;
    logic [31:0] wait_r;
    logic [1:0] cfg_idx_r;
    logic configured_r; // channel setup survives sleep
    logic clk_run_r;
    wire wait_done = (wait_r == 32'h0000_0000);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= S_OFF;
            wait_r <= 32'h0000_0000;
            cfg_idx_r <= 2'h0;
            configured_r <= 1'b0;
            clk_run_r <= 1'b0;
            bus.shutdown_n_pin <= 1'b0;
            bus.wr_valid <= 1'b0;
            bus.rd_valid <= 1'b0;
            bus.addr <= 8'h00;
            bus.wdata <= 8'h00;
        end else begin
            bus.wr_valid <= 1'b0;
            bus.rd_valid <= 1'b0;
            if (!wait_done) wait_r <= wait_r - 32'h0000_0001;
            if (shutdown_req || !sup_r) begin
                // pin low at any time drops the whole sequence
                st_r <= S_OFF;
                bus.shutdown_n_pin <= 1'b0;
                clk_run_r <= 1'b0;
                configured_r <= 1'b0;
            end else begin
                case (st_r)
                    S_OFF: begin
                        bus.shutdown_n_pin <= 1'b1;
                        wait_r <= 32'(INIT_CYC);
                        st_r <= S_INIT;
                    end
                    S_INIT: if (wait_done) st_r <= S_SLEEP;
                    S_SLEEP: if (record_req) begin
                        bus.wr_valid <= 1'b1;
                        bus.addr <= pwr_seq_pkg::SLEEP_CONTROL_ADDR;
                        bus.wdata <= pwr_seq_pkg::WAKE_VALUE;
                        wait_r <= 32'(WAKE_CYC);
                        st_r <= configured_r ? S_REWAKE : S_WAKE;
                    end
                    S_WAKE: if (wait_done) begin
                        // defaults left in force: no optional overrides
                        clk_run_r <= 1'b1;
                        cfg_idx_r <= 2'h0;
                        st_r <= S_CFG;
                    end
                    S_CFG: begin
                        bus.wr_valid <= 1'b1;
                        case (cfg_idx_r)
                            2'h0: begin
                                bus.addr <= pwr_seq_pkg::INPUT_CHANNEL_ENABLE_ADDR;
                                bus.wdata <= pwr_seq_pkg::CHANNEL_EN_VALUE;
                            end
                            2'h1: begin
                                bus.addr <= pwr_seq_pkg::OUTPUT_SLOT_ENABLE_ADDR;
                                bus.wdata <= pwr_seq_pkg::SLOT_EN_VALUE;
                            end
                            default: begin
                                bus.addr <= pwr_seq_pkg::BLOCK_POWER_UP_ADDR;
                                bus.wdata <= pwr_seq_pkg::POWER_UP_VALUE;
                            end
                        endcase
                        cfg_idx_r <= cfg_idx_r + 2'h1;
                        if (cfg_idx_r == 2'h2) begin
                            configured_r <= 1'b1;
                            st_r <= S_RUN;
                        end
                    end
                    S_RUN: if (!record_req) begin
                        bus.wr_valid <= 1'b1;
                        bus.addr <= pwr_seq_pkg::SLEEP_CONTROL_ADDR;
                        bus.wdata <= pwr_seq_pkg::SLEEP_VALUE;
                        wait_r <= 32'(SLEEP_CYC);
                        st_r <= S_ENTER;
                    end
                    S_ENTER: if (wait_done) st_r <= S_POLL;
                    S_POLL: begin
                        bus.rd_valid <= 1'b1;
                        bus.addr <= pwr_seq_pkg::DEVICE_STATUS_ADDR;
                        st_r <= S_PWAIT;
                    end
                    S_PWAIT: if (bus.rdata_valid) begin
                        if (bus.rdata[pwr_seq_pkg::STATUS_SLEEP_BIT]) begin
                            clk_run_r <= 1'b0;
                            st_r <= S_SLEEP;
                        end else begin
                            st_r <= S_POLL;
                        end
                    end
                    S_REWAKE: if (wait_done) begin
                        clk_run_r <= 1'b1;
                        st_r <= S_RUN;
                    end
                    default: st_r <= S_OFF;
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // serial clock enables: bit pulse every BCLK_DIV, frame each 32 bits
    // ---------------------------------------------------------------
    localparam int FRAME_BITS = pwr_seq_pkg::SLOT_BITS * pwr_seq_pkg::SLOTS;
    logic [7:0] div_r;
    logic [7:0] bitn_r;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= 8'h00;
            bitn_r <= 8'h00;
            bus.bit_clk <= 1'b0;
            bus.frame_sync <= 1'b0;
        end else begin
            bus.bit_clk <= 1'b0;
            bus.frame_sync <= 1'b0;
            if (!clk_run_r) begin
                div_r <= 8'h00;
                bitn_r <= 8'h00;
            end else if (div_r == 8'(BCLK_DIV - 1)) begin
                div_r <= 8'h00;
                bus.bit_clk <= 1'b1;
                bus.frame_sync <= (bitn_r == 8'h00);
                bitn_r <= (bitn_r == 8'(FRAME_BITS - 1)) ? 8'h00 : bitn_r + 8'h01;
            end else begin
                div_r <= div_r + 8'h01;
            end
        end
    end

    // ---------------------------------------------------------------
    // sample capture: device drives data after each bit pulse
    // ---------------------------------------------------------------
    logic cap_r;
    logic [7:0] sh_r;
    logic [2:0] bc_r;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_r <= 1'b0;
            sh_r <= 8'h00;
            bc_r <= 3'h0;
            sample_o <= 8'h00;
            sample_valid_o <= 1'b0;
        end else begin
            cap_r <= bus.bit_clk;
            sample_valid_o <= 1'b0;
            if (bus.frame_sync) bc_r <= 3'h0;
            if (cap_r && st_r == S_RUN) begin
                sh_r <= {sh_r[6:0], bus.serial_data};
                bc_r <= bc_r + 3'h1;
                if (bc_r == 3'h7) begin
                    sample_o <= {sh_r[6:0], bus.serial_data};
                    sample_valid_o <= 1'b1;
                end
            end
        end
    end

    // status outputs
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            active_o <= 1'b0;
            asleep_o <= 1'b0;
        end else begin
            active_o <= (st_r == S_RUN);
            asleep_o <= (st_r == S_SLEEP);
        end
    end
endmodule // pwr_seq_host
`default_nettype wire

// [hw/pwr_seq_dev.sv]
// device end: power-mode state, register file and serial output
`timescale 1ns/10ps
`default_nettype none
module pwr_seq_dev #(
    parameter int INIT_CYC = pwr_seq_pkg::DEV_INIT_CYC,
    parameter int WAKE_CYC = pwr_seq_pkg::DEV_WAKE_CYC,
    parameter int RAMP_CYC = pwr_seq_pkg::DEV_SLEEP_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] adc_sample, // user-side converter word
    output logic [1:0] mode_o, // 0 hw shutdown,1 sleep,2 waking,3 active
    output logic recording_o,
    output logic [7:0] chan_en_o,
    pwr_seq_if.dev bus
);
    initial begin
        if (INIT_CYC < 1 || WAKE_CYC < 1 || RAMP_CYC < 1) begin
            $error("pwr_seq_dev: bad parameter");
        end
    end

    typedef enum logic [5:0] {
        D_HWSD = 6'h01, D_INIT = 6'h02, D_SLEEP = 6'h04, D_WAKE = 6'h08,
        D_ACTIVE = 6'h10, D_RAMP = 6'h20
    } dstate_t;

    // shutdown pin comes from another chip: two flops first
    logic sd_m_r, sd_r;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sd_m_r <= 1'b0;
            sd_r <= 1'b0;
        end else begin
            sd_m_r <= bus.shutdown_n_pin;
            sd_r <= sd_m_r;
        end
    end

    // ---------------------------------------------------------------
    // mode sequencing
    // ---------------------------------------------------------------
    dstate_t st_r;
    logic [31:0] cnt_r;
    logic [7:0] sleep_ctl_r, chan_r, slot_r, pwr_r;
    wire wr_sleep = bus.wr_valid && bus.addr == pwr_seq_pkg::SLEEP_CONTROL_ADDR;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= D_HWSD;
            cnt_r <= 32'h0000_0000;
        end else if (!sd_r) begin
            st_r <= D_HWSD;
        end else begin
            if (cnt_r != 32'h0000_0000) cnt_r <= cnt_r - 32'h0000_0001;
            case (st_r)
                D_HWSD: begin
                    cnt_r <= 32'(INIT_CYC);
                    st_r <= D_INIT;
                end
                D_INIT: if (cnt_r == 32'h0000_0000) st_r <= D_SLEEP;
                // bit0 set means sleep off (wake value), clear means sleep on
                D_SLEEP: if (wr_sleep && bus.wdata[pwr_seq_pkg::SLEEP_BIT]) begin
                    cnt_r <= 32'(WAKE_CYC);
                    st_r <= D_WAKE;
                end
                D_WAKE: if (cnt_r == 32'h0000_0000) st_r <= D_ACTIVE;
                D_ACTIVE: if (wr_sleep && !bus.wdata[pwr_seq_pkg::SLEEP_BIT]) begin
                    cnt_r <= 32'(RAMP_CYC);
                    st_r <= D_RAMP;
                end
                D_RAMP: if (cnt_r == 32'h0000_0000) st_r <= D_SLEEP;
                default: st_r <= D_HWSD;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // registers: cleared only by hardware shutdown, kept through sleep
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_ctl_r <= pwr_seq_pkg::SLEEP_CONTROL_RST;
            chan_r <= pwr_seq_pkg::ENABLE_RST;
            slot_r <= pwr_seq_pkg::ENABLE_RST;
            pwr_r <= pwr_seq_pkg::ENABLE_RST;
        end else if (st_r == D_HWSD || st_r == D_INIT) begin
            // init phase reloads defaults; writes are not accepted then
            sleep_ctl_r <= pwr_seq_pkg::SLEEP_CONTROL_RST;
            chan_r <= pwr_seq_pkg::ENABLE_RST;
            slot_r <= pwr_seq_pkg::ENABLE_RST;
            pwr_r <= pwr_seq_pkg::ENABLE_RST;
        end else if (bus.wr_valid) begin // sleep itself touches nothing
            case (bus.addr)
                pwr_seq_pkg::SLEEP_CONTROL_ADDR: sleep_ctl_r <= bus.wdata;
                pwr_seq_pkg::INPUT_CHANNEL_ENABLE_ADDR: chan_r <= bus.wdata;
                pwr_seq_pkg::OUTPUT_SLOT_ENABLE_ADDR: slot_r <= bus.wdata;
                pwr_seq_pkg::BLOCK_POWER_UP_ADDR: pwr_r <= bus.wdata;
                default: ;
            endcase
        end
    end

    // read port: one cycle latency, unmapped reads zero
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus.rdata <= 8'h00;
            bus.rdata_valid <= 1'b0;
        end else begin
            bus.rdata_valid <= bus.rd_valid;
            case (bus.addr)
                pwr_seq_pkg::SLEEP_CONTROL_ADDR: bus.rdata <= sleep_ctl_r;
                pwr_seq_pkg::INPUT_CHANNEL_ENABLE_ADDR: bus.rdata <= chan_r;
                pwr_seq_pkg::OUTPUT_SLOT_ENABLE_ADDR: bus.rdata <= slot_r;
                pwr_seq_pkg::BLOCK_POWER_UP_ADDR: bus.rdata <= pwr_r;
                pwr_seq_pkg::DEVICE_STATUS_ADDR:
                    bus.rdata <= {(st_r == D_SLEEP || st_r == D_HWSD), 7'h00};
                default: bus.rdata <= 8'h00;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // tdm output: slot n carries the sample when active, block power up nonzero, and channel and slot enabled
    // ---------------------------------------------------------------
    logic [7:0] shift_r;
    logic [4:0] bit_r;
    wire run = (st_r == D_ACTIVE) && (pwr_r != 8'h00);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_r <= 8'h00;
            bit_r <= 5'h00;
            bus.serial_data <= 1'b0;
        end else if (bus.bit_clk) begin
            logic [1:0] slot;
            slot = bus.frame_sync ? 2'h0 : bit_r[4:3];
            if (bus.frame_sync) bit_r <= 5'h01;
            else bit_r <= bit_r + 5'h01;
            if (bus.frame_sync || bit_r[2:0] == 3'h0) begin
                if (run && chan_r[7 - slot] && slot_r[7 - slot]) begin
                    bus.serial_data <= adc_sample[7];
                    shift_r <= {adc_sample[6:0], 1'b0};
                end else begin
                    bus.serial_data <= 1'b0;
                    shift_r <= 8'h00;
                end
            end else begin
                bus.serial_data <= shift_r[7];
                shift_r <= {shift_r[6:0], 1'b0};
            end
        end
    end

    // status outputs
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_o <= 2'h0;
            recording_o <= 1'b0;
            chan_en_o <= 8'h00;
        end else begin
            mode_o <= (st_r == D_HWSD) ? 2'h0 :
                      (st_r == D_ACTIVE) ? 2'h3 :
                      (st_r == D_WAKE) ? 2'h2 : 2'h1;
            recording_o <= run;
            chan_en_o <= chan_r;
        end
    end
endmodule // pwr_seq_dev
`default_nettype wire

// [test/pwr_seq_assertions.sv]
// checker on the control and serial lines between host and device ends
`timescale 1ns/10ps
`default_nettype none
module pwr_seq_assertions #(
    parameter int INIT_CYC = 20,
    parameter int WAKE_CYC = 20,
    parameter int SLEEP_CYC = 60
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic shutdown_n_pin,
    input wire logic wr_valid,
    input wire logic rd_valid,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic rdata_valid,
    input wire logic frame_sync,
    input wire logic bit_clk,
    input wire logic serial_data
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic wake_w, sleep_w;
    int up_r, wake_r, slp_r, gap_r;
    logic [7:0] last_r;
    logic woke_r, pend_r;
    assign wake_w = wr_valid && addr == pwr_seq_pkg::SLEEP_CONTROL_ADDR
        && wdata == pwr_seq_pkg::WAKE_VALUE;
    assign sleep_w = wr_valid && addr == pwr_seq_pkg::SLEEP_CONTROL_ADDR
        && wdata == pwr_seq_pkg::SLEEP_VALUE;
    // saturating ages of pin release, wake write, sleep write, last bit pulse
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            up_r <= 0;
            wake_r <= 0;
            slp_r <= 0;
            gap_r <= 0;
        end else begin
            up_r <= !shutdown_n_pin ? 0 : (up_r < 1000 ? up_r + 1 : up_r);
            wake_r <= (wake_w || !shutdown_n_pin) ? 0 : (wake_r < 1000 ? wake_r + 1 : wake_r);
            slp_r <= sleep_w ? 0 : (slp_r < 1000 ? slp_r + 1 : slp_r);
            gap_r <= bit_clk ? 0 : (gap_r < 1000 ? gap_r + 1 : gap_r);
        end
    end
    // order tracking; a pin drop forgets any wake so clocks must stop with it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            last_r <= 8'h00;
            woke_r <= 1'b0;
            pend_r <= 1'b0;
        end else begin
            if (wr_valid) last_r <= addr;
            woke_r <= shutdown_n_pin && (woke_r || wake_w);
            pend_r <= shutdown_n_pin && (sleep_w || (pend_r && !(rdata_valid && rdata[7])));
        end
    end
    no_early_write_a: assert property (wr_valid |-> up_r >= INIT_CYC)
        else $error("write before init wait");
    sleep_reg_value_a: assert property (wr_valid && addr == pwr_seq_pkg::SLEEP_CONTROL_ADDR
        |-> wdata == pwr_seq_pkg::WAKE_VALUE || wdata == pwr_seq_pkg::SLEEP_VALUE)
        else $error("bad sleep control value");
    cfg_after_wake_a: assert property (wr_valid && addr != pwr_seq_pkg::SLEEP_CONTROL_ADDR
        |-> wake_r >= WAKE_CYC)
        else $error("config before wake wait");
    chan_value_a: assert property (wr_valid && addr == pwr_seq_pkg::INPUT_CHANNEL_ENABLE_ADDR
        |-> wdata == pwr_seq_pkg::CHANNEL_EN_VALUE)
        else $error("bad channel enable value");
    slot_order_a: assert property (wr_valid && addr == pwr_seq_pkg::OUTPUT_SLOT_ENABLE_ADDR
        |-> last_r == pwr_seq_pkg::INPUT_CHANNEL_ENABLE_ADDR
        && wdata == pwr_seq_pkg::SLOT_EN_VALUE)
        else $error("slot write out of order");
    power_order_a: assert property (wr_valid && addr == pwr_seq_pkg::BLOCK_POWER_UP_ADDR
        |-> last_r == pwr_seq_pkg::OUTPUT_SLOT_ENABLE_ADDR
        && wdata == pwr_seq_pkg::POWER_UP_VALUE)
        else $error("power write out of order");
    clk_after_wake_a: assert property (bit_clk |-> woke_r && shutdown_n_pin)
        else $error("serial clock without wake");
    status_wait_a: assert property (rd_valid && pend_r |-> slp_r >= SLEEP_CYC)
        else $error("status read before ramp wait");
    clk_until_status_a: assert property (pend_r |-> gap_r <= 8)
        else $error("clocks stopped before status");
    read_answer_a: assert property (rd_valid |=> rdata_valid ##1 !rdata_valid)
        else $error("read answer missing");
    frame_on_bit_a: assert property (frame_sync |-> bit_clk)
        else $error("frame sync off bit pulse");
endmodule // pwr_seq_assertions
`default_nettype wire

// [test/test_audio_adc_power_mode_sequencer.sv]
// self-checking bench joining host and device ends over the power-mode link
`timescale 1ns/10ps
`default_nettype none
module test_audio_adc_power_mode_sequencer;
    localparam int HI = 20;
    localparam int HW = 20;
    localparam int HS = 60;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic supplies_ok = 1'b0;
    logic record_req = 1'b0;
    logic shutdown_req = 1'b0;
    logic quiet = 1'b0;
    logic [7:0] adc_sample = 8'h00;
    logic [7:0] seed = 8'h19;
    logic active_o, asleep_o, sample_valid_o, recording_o;
    logic [7:0] sample_o, chan_en_o;
    logic [1:0] mode_o;
    logic [7:0] exp_q[$];
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    pwr_seq_if link ();
    pwr_seq_host #(.INIT_CYC(HI), .WAKE_CYC(HW), .SLEEP_CYC(HS), .BCLK_DIV(4)) i_pwr_seq_host (
        .core_clk(core_clk), .rst_n(rst_n), .supplies_ok(supplies_ok), .record_req(record_req),
        .shutdown_req(shutdown_req), .active_o(active_o), .asleep_o(asleep_o),
        .sample_o(sample_o), .sample_valid_o(sample_valid_o), .bus(link.host));
    pwr_seq_dev #(.INIT_CYC(10), .WAKE_CYC(10), .RAMP_CYC(30)) i_pwr_seq_dev (
        .core_clk(core_clk), .rst_n(rst_n), .adc_sample(adc_sample), .mode_o(mode_o),
        .recording_o(recording_o), .chan_en_o(chan_en_o), .bus(link.dev));
    pwr_seq_assertions #(.INIT_CYC(HI), .WAKE_CYC(HW), .SLEEP_CYC(HS)) i_pwr_seq_assertions (
        .core_clk(core_clk), .rst_n(rst_n), .shutdown_n_pin(link.shutdown_n_pin),
        .wr_valid(link.wr_valid), .rd_valid(link.rd_valid), .addr(link.addr),
        .wdata(link.wdata), .rdata(link.rdata), .rdata_valid(link.rdata_valid),
        .frame_sync(link.frame_sync), .bit_clk(link.bit_clk), .serial_data(link.serial_data));
    // 100 ns period
    initial begin
        forever #50 core_clk = ~core_clk;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // bounded wait: 0 active, 1 asleep, 2 hardware shutdown, 3 one slot word
    task automatic wait_on(input int sel);
        int n;
        n = 0;
        while (n < 3000 && !((sel == 0 && active_o === 1'b1) || (sel == 1 && asleep_o === 1'b1)
            || (sel == 2 && mode_o === 2'd0) || (sel == 3 && sample_valid_o === 1'b1))) begin
            @(negedge core_clk);
            n++;
        end
        if (n == 3000) check("wait", 8'h00, 8'h01);
        @(negedge core_clk);
    endtask
    // words already framed carry the old sample, so flush a full frame first
    task automatic run_samples();
        seed = lfsr(seed);
        adc_sample = seed;
        repeat (5) wait_on(3);
        repeat (3) exp_q.push_back(seed);
        repeat (3) wait_on(3);
    endtask
    // oldest note against each captured word while notes are queued; sampled mid-cycle where outputs are settled
    // once asleep neither a bit pulse nor a word may appear
    always @(negedge core_clk) begin
        if (quiet && (link.bit_clk !== 1'b0 || sample_valid_o !== 1'b0)) begin
            check("clock or word in sleep", {6'h00, link.bit_clk, sample_valid_o}, 8'h00);
        end else if (sample_valid_o === 1'b1 && exp_q.size() > 0) begin
            check("slot word", sample_o, exp_q.pop_front());
        end
    end
    // hang guard, far above the 1500 or so cycles the sequence needs
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            check("timeout", 8'h00, 8'h01);
            summarize();
        end
    end
    initial begin
        repeat (3) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (40) @(negedge core_clk);
        check("pin before supplies", {7'h00, link.shutdown_n_pin}, 8'h00);
        check("mode before supplies", {6'h00, mode_o}, 8'h00);
        supplies_ok = 1'b1;
        record_req = 1'b1;
        for (int k = 0; k < 3; k++) begin
            wait_on(0);
            check("mode active", {6'h00, mode_o}, 8'h03);
            check("channel enable", chan_en_o, pwr_seq_pkg::CHANNEL_EN_VALUE);
            check("recording", {7'h00, recording_o}, 8'h01);
            run_samples();
            if (k < 2) begin
                record_req = 1'b0;
                wait_on(1);
                check("mode asleep", {6'h00, mode_o}, 8'h01);
                check("kept channels", chan_en_o, pwr_seq_pkg::CHANNEL_EN_VALUE);
                check("recording in sleep", {7'h00, recording_o}, 8'h00);
                quiet = 1'b1;
                repeat (200) @(negedge core_clk);
                quiet = 1'b0;
                if (k == 1) begin
                    shutdown_req = 1'b1;
                    wait_on(2);
                    check("pin forced low", {7'h00, link.shutdown_n_pin}, 8'h00);
                    shutdown_req = 1'b0;
                end
                record_req = 1'b1;
            end
        end
        summarize();
    end
endmodule // test_audio_adc_power_mode_sequencer
`default_nettype wire
